/* hdl/e1_pkg.sv */
// Constants shared by the receive control/identity register end and its host controller.
// Assumes one system clock of 125 MHz for both ends and the register link between them.
// Notes on behaviour
// - Identity register at 0Fh, read-only, type field
// - Identity low nibble reports decimal chip revision
// - Identity register exists only in first transceiver
// - Host clears test registers 1E, 1F, 2F
// - Host writes every register after power-up
// - Host raises line-interface reset bit after writes
// - Reset bit rise holds line interface 40 ms
// - Host finally raises both elastic-store reset bits
// - Bit 7 picks CAS or CRC4 multiframe
// - Bit 6 picks frame or multiframe sync
// - Bit 5 sets sync pin direction
// - Host keeps direction zero while store disabled
// - Bit 4 enables elastic store, else bypass
// - Host writes zero to unused bit 3
// - Bit 2 selects three-error resync criterion
// - Bit 1 disables automatic resync
// - Bit 0 rise starts one resync
// - Align on FAS present N, absent N+1, present N+2
package e1_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam logic [5:0] REG_ID = 6'h0f;
  localparam logic [5:0] REG_RX_CTRL = 6'h10;
  localparam logic [5:0] REG_COMMON_4 = 6'h15;
  localparam logic [5:0] REG_COMMON_5 = 6'h16;
  localparam logic [5:0] REG_TEST_A = 6'h1e;
  localparam logic [5:0] REG_TEST_B = 6'h1f;
  localparam logic [5:0] REG_TEST_C = 6'h2f;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int RX_MF_TYPE = 7;
  localparam int RX_MODE = 6;
  localparam int RX_DIR = 5;
  localparam int RX_ES_EN = 4;
  localparam int RX_UNUSED = 3;
  localparam int RX_CRIT = 2;
  localparam int RX_AUTO_DIS = 1;
  localparam int RX_RESYNC = 0;
  localparam int LI_RESET_BIT = 4;
  localparam int ES_RESET_LO = 5;
  localparam int ES_RESET_HI = 6;
  localparam logic [7:0] LI_RESET_VAL = 8'h10;
  localparam logic [7:0] ES_RESET_VAL = 8'h60;
  localparam logic [1:0] ERR_LIMIT = 2'h3;
  localparam int CLK_MHZ = 125;
  localparam int LI_RECOVER_US = 40000;
  localparam int LI_RECOVER_CYCLES = LI_RECOVER_US * CLK_MHZ;
  localparam int LI_CNT_W = 23;
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_STATUS = 8'h04;
  localparam logic [7:0] HOST_CTRL = 8'h08;
  localparam int CMD_WR_BIT = 16;
  localparam int CMD_ADDR_LSB = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_INIT_DONE = 1;
  localparam int STAT_RDATA_LSB = 8;
  localparam int CTRL_INIT = 0;
  localparam int CTRL_RESYNC = 1;
  localparam logic [2:0] INIT_LAST = 3'h7;
  localparam logic [1:0] REALIGN_CLEAR = 2'h2;
  localparam logic [1:0] REALIGN_SET = 2'h1;
endpackage : e1_pkg

/* hdl/e1_link_if.sv */
// Register link between the host controller and the receive control register end.
// Assumes both ends run on the same clk_sys; every signal changes after a rising edge.
`timescale 1ns/1ps
interface e1_link_if;
  logic portWr;
  logic portRd;
  logic [e1_pkg::ADDR_W-1:0] portAddr;
  logic [e1_pkg::DATA_W-1:0] portWdata;
  logic [e1_pkg::DATA_W-1:0] portRdata;
  logic portRvalid;
  modport host(
    output portWr,
    output portRd,
    output portAddr,
    output portWdata,
    input portRdata,
    input portRvalid
  );
  modport dev(
    input portWr,
    input portRd,
    input portAddr,
    input portWdata,
    output portRdata,
    output portRvalid
  );
endinterface : e1_link_if

/* hdl/e1_rx_control_id_regs.sv */
// Device end: identity, receive control, test and common control 4/5 registers,
// FAS alignment search, receive sync pin control and reset pulse generation.
// Assumes frame strobes and checks come from framer logic on clk_sys; pins are async.
//
// The register link device port is this design's own decision.
`timescale 1ns/1ps
module e1_rx_control_id_regs #(
  parameter int LI_RECOVER_CYC = e1_pkg::LI_RECOVER_CYCLES,
  // Arbitrary value
  parameter logic [3:0] REVISION = 4'h3,
  // Arbitrary value
  parameter logic TYPE_FLAG = 1'b0
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  e1_link_if.dev link,
  input wire logic transceiverSelect0,
  input wire logic transceiverSelect1,
  input wire logic frameStrobe,
  input wire logic fasOk,
  input wire logic nfasBit2Err,
  input wire logic casMfStrobe,
  input wire logic crc4MfStrobe,
  input wire logic rxSyncIn,
  output logic rxSyncOut,
  output logic rxSyncOe,
  output logic esEnable,
  output logic esSyncIn,
  output logic [1:0] esReset,
  output logic liReset,
  output logic frameAligned,
  output logic alignLost,
  output logic resyncPulse
);
  import e1_pkg::*;

  typedef enum logic [3:0] {
    ST_HUNT = 4'b0001,
    ST_GAP = 4'b0010,
    ST_CONFIRM = 4'b0100,
    ST_LOCKED = 4'b1000
  } align_e;

  logic [7:0] rxCtrl;
  logic [7:0] common4;
  logic [7:0] common5;
  logic [7:0] testA;
  logic [7:0] testB;
  logic [7:0] testC;
  logic resyncPrev;
  logic [1:0] esResetPrev;
  logic liPrev;
  logic [LI_CNT_W-1:0] liCnt;
  logic [2:0] pinMeta;
  logic [2:0] pinSync;
  align_e state;
  align_e next_state;
  logic [1:0] fasErr;
  logic [1:0] next_fasErr;
  logic [1:0] nfasErr;
  logic [1:0] next_nfasErr;
  logic fasFrame;
  logic next_fasFrame;
  logic next_lost;

  // Register decode
  wire wrRxCtrl = link.portWr && link.portAddr == REG_RX_CTRL;
  wire wrCommon4 = link.portWr && link.portAddr == REG_COMMON_4;
  wire wrCommon5 = link.portWr && link.portAddr == REG_COMMON_5;
  wire wrTestA = link.portWr && link.portAddr == REG_TEST_A;
  wire wrTestB = link.portWr && link.portAddr == REG_TEST_B;
  wire wrTestC = link.portWr && link.portAddr == REG_TEST_C;
  // Straps are read only after two flops; channel 1 is select 00
  wire isFirst = pinSync[1:0] == 2'b00;
  wire [7:0] idValue = {TYPE_FLAG, 3'b000, REVISION};
  wire [7:0] readValue =
    (link.portAddr == REG_ID) ? (isFirst ? idValue : 8'h00) :
    (link.portAddr == REG_RX_CTRL) ? rxCtrl :
    (link.portAddr == REG_COMMON_4) ? common4 :
    (link.portAddr == REG_COMMON_5) ? common5 :
    (link.portAddr == REG_TEST_A) ? testA :
    (link.portAddr == REG_TEST_B) ? testB :
    (link.portAddr == REG_TEST_C) ? testC : 8'h00;

  // Edge detectors on register bits
  wire resyncStart = rxCtrl[RX_RESYNC] && !resyncPrev;
  wire liRise = common5[LI_RESET_BIT] && !liPrev;
  wire [1:0] esResetRise = common4[ES_RESET_HI:ES_RESET_LO] & ~esResetPrev;

  // Sync pin as input is only honoured with the store enabled
  wire inputMode = rxCtrl[RX_DIR] && rxCtrl[RX_ES_EN];
  wire mfPulse = rxCtrl[RX_MF_TYPE] ? crc4MfStrobe : casMfStrobe;
  wire syncSrc = rxCtrl[RX_MODE] ? mfPulse : frameStrobe;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rxCtrl <= REG_RESET;
      common4 <= REG_RESET;
      common5 <= REG_RESET;
      testA <= REG_RESET;
      testB <= REG_RESET;
      testC <= REG_RESET;
    end
    else
    begin
      if (wrRxCtrl)
        rxCtrl <= link.portWdata;
      if (wrCommon4)
        common4 <= link.portWdata;
      if (wrCommon5)
        common5 <= link.portWdata;
      if (wrTestA)
        testA <= link.portWdata;
      if (wrTestB)
        testB <= link.portWdata;
      if (wrTestC)
        testC <= link.portWdata;
    end
  end

  // Read answers one cycle after the strobe
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link.portRdata <= 8'h00;
      link.portRvalid <= 1'b0;
    end
    else
    begin
      link.portRvalid <= link.portRd;
      if (link.portRd)
        link.portRdata <= readValue;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinMeta <= 3'h0;
      pinSync <= 3'h0;
    end
    else
    begin
      pinMeta <= {rxSyncIn, transceiverSelect1, transceiverSelect0};
      pinSync <= pinMeta;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      resyncPrev <= 1'b0;
      esResetPrev <= 2'h0;
      liPrev <= 1'b0;
      resyncPulse <= 1'b0;
      esReset <= 2'h0;
    end
    else
    begin
      resyncPrev <= rxCtrl[RX_RESYNC];
      esResetPrev <= common4[ES_RESET_HI:ES_RESET_LO];
      liPrev <= common5[LI_RESET_BIT];
      resyncPulse <= resyncStart;
      esReset <= esResetRise;
    end
  end

  // Long hold so the line interface settles before use
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      liCnt <= '0;
      liReset <= 1'b0;
    end
    else if (liRise)
    begin
      liCnt <= LI_CNT_W'(LI_RECOVER_CYC);
      liReset <= 1'b1;
    end
    else if (liCnt != '0)
    begin
      liCnt <= LI_CNT_W'(liCnt - 1'b1);
      liReset <= liCnt != LI_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rxSyncOut <= 1'b0;
      rxSyncOe <= 1'b1;
      esEnable <= 1'b0;
      esSyncIn <= 1'b0;
    end
    else
    begin
      rxSyncOut <= syncSrc && !inputMode;
      rxSyncOe <= !inputMode;
      esEnable <= rxCtrl[RX_ES_EN];
      esSyncIn <= pinSync[2] && inputMode;
    end
  end

  // Alignment search and loss counting
  always_comb
  begin
    next_state = state;
    next_fasErr = fasErr;
    next_nfasErr = nfasErr;
    next_fasFrame = fasFrame;
    next_lost = alignLost;
    if (resyncStart)
    begin
      next_state = ST_HUNT;
      next_fasErr = 2'h0;
      next_nfasErr = 2'h0;
    end
    else if (frameStrobe)
    begin
      case (state)
        ST_HUNT:
          if (fasOk)
            next_state = ST_GAP;
        ST_GAP:
          if (!fasOk)
            next_state = ST_CONFIRM;
        ST_CONFIRM:
          if (fasOk)
          begin
            next_state = ST_LOCKED;
            next_fasFrame = 1'b0;
            next_fasErr = 2'h0;
            next_nfasErr = 2'h0;
            next_lost = 1'b0;
          end
          else
            next_state = ST_HUNT;
        ST_LOCKED:
        begin
          next_fasFrame = !fasFrame;
          if (fasFrame)
            next_fasErr = fasOk ? 2'h0 : 2'(fasErr + 2'h1);
          else if (rxCtrl[RX_CRIT] && nfasBit2Err)
            next_nfasErr = 2'(nfasErr + 2'h1);
          else
            next_nfasErr = 2'h0;
          if (next_fasErr == ERR_LIMIT || next_nfasErr == ERR_LIMIT)
          begin
            next_lost = 1'b1;
            next_fasErr = 2'h0;
            next_nfasErr = 2'h0;
            if (!rxCtrl[RX_AUTO_DIS])
              next_state = ST_HUNT;
          end
        end
        default:
          next_state = ST_HUNT;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_HUNT;
      fasErr <= 2'h0;
      nfasErr <= 2'h0;
      fasFrame <= 1'b0;
      alignLost <= 1'b0;
      frameAligned <= 1'b0;
    end
    else
    begin
      state <= next_state;
      fasErr <= next_fasErr;
      nfasErr <= next_nfasErr;
      fasFrame <= next_fasFrame;
      alignLost <= next_lost;
      frameAligned <= next_state == ST_LOCKED && !next_lost;
    end
  end
endmodule : e1_rx_control_id_regs

/* hdl/e1_host_ctrl.sv */
// Host end: AHB-Lite slave with command, status and control words,
// a power-up init sequencer and a manual resync helper driving the register link.
// Assumes one AHB master, zero-wait answers and the device on the same clk_sys.
`timescale 1ns/1ps
module e1_host_ctrl (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  e1_link_if.host link
);
  import e1_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } link_e;

  link_e state;
  logic dpWr;
  logic [7:0] dpAddr;
  logic [16:0] cmdReg;
  logic cmdPend;
  logic initRun;
  logic initDone;
  logic [2:0] initIdx;
  logic [1:0] realignStep;
  logic [7:0] rxCtrlShadow;
  logic [7:0] lastRdata;

  // Power-up order: tests cleared, all registers written, then the two reset edges
  function automatic logic [13:0] initStep(input logic [2:0] idx);
    case (idx)
      3'h0: initStep = {REG_TEST_A, REG_RESET};
      3'h1: initStep = {REG_TEST_B, REG_RESET};
      3'h2: initStep = {REG_TEST_C, REG_RESET};
      3'h3: initStep = {REG_RX_CTRL, REG_RESET};
      3'h4: initStep = {REG_COMMON_4, REG_RESET};
      3'h5: initStep = {REG_COMMON_5, REG_RESET};
      3'h6: initStep = {REG_COMMON_5, LI_RESET_VAL};
      default: initStep = {REG_COMMON_4, ES_RESET_VAL};
    endcase
  endfunction : initStep

  wire busy = state != ST_IDLE || cmdPend || initRun || realignStep != 2'h0;
  wire apTake = hsel && hready && htrans[1];
  wire [31:0] status = {16'h0, lastRdata, 6'h0, initDone, busy};
  wire [31:0] readMux = (haddr[7:0] == HOST_STATUS) ? status :
    (haddr[7:0] == HOST_CMD) ? {15'h0, cmdReg} : 32'h0;
  // Commands arriving while busy are dropped; software polls the busy bit
  wire cmdWrite = dpWr && dpAddr == HOST_CMD && !busy;
  wire ctrlWrite = dpWr && dpAddr == HOST_CTRL && !busy;
  wire idle = state == ST_IDLE;
  wire pickInit = idle && initRun;
  wire pickRealign = idle && !initRun && realignStep != 2'h0;
  wire pickCmd = idle && !initRun && realignStep == 2'h0 && cmdPend;
  wire issue = pickInit || pickRealign || pickCmd;
  wire [13:0] initWord = initStep(initIdx);
  wire [5:0] iAddr = pickInit ? initWord[13:8] :
    pickRealign ? REG_RX_CTRL : cmdReg[CMD_ADDR_LSB +: 6];
  wire [7:0] realignData = {rxCtrlShadow[7:1], realignStep == REALIGN_SET};
  wire [7:0] iData = pickInit ? initWord[7:0] : pickRealign ? realignData : cmdReg[7:0];
  wire iWr = pickInit || pickRealign || cmdReg[CMD_WR_BIT];
  wire isRxCtrl = iAddr == REG_RX_CTRL;
  wire dirFix = iData[RX_DIR] && iData[RX_ES_EN];
  wire [7:0] rxCtrlFixed = {iData[7:6], dirFix, iData[4], 1'b0, iData[2:0]};
  wire [7:0] oData = isRxCtrl ? rxCtrlFixed : iData;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dpWr <= 1'b0;
      dpAddr <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      dpWr <= apTake && hwrite;
      dpAddr <= haddr[7:0];
      hrdata <= (apTake && !hwrite) ? readMux : 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmdReg <= 17'h0;
      cmdPend <= 1'b0;
      initRun <= 1'b0;
      initDone <= 1'b0;
      initIdx <= 3'h0;
      realignStep <= 2'h0;
    end
    else
    begin
      if (cmdWrite)
      begin
        cmdReg <= hwdata[16:0];
        cmdPend <= 1'b1;
      end
      else if (pickCmd)
        cmdPend <= 1'b0;
      if (ctrlWrite && hwdata[CTRL_INIT])
      begin
        initRun <= 1'b1;
        initDone <= 1'b0;
        initIdx <= 3'h0;
      end
      else if (pickInit)
      begin
        initIdx <= 3'(initIdx + 3'h1);
        initRun <= initIdx != INIT_LAST;
        initDone <= initIdx == INIT_LAST;
      end
      if (ctrlWrite && hwdata[CTRL_RESYNC] && !hwdata[CTRL_INIT])
        realignStep <= REALIGN_CLEAR;
      else if (pickRealign)
        realignStep <= 2'(realignStep - 2'h1);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_IDLE;
      link.portWr <= 1'b0;
      link.portRd <= 1'b0;
      link.portAddr <= 6'h0;
      link.portWdata <= 8'h00;
      rxCtrlShadow <= REG_RESET;
      lastRdata <= 8'h00;
    end
    else
    begin
      link.portWr <= issue && iWr;
      link.portRd <= issue && !iWr;
      if (issue)
      begin
        link.portAddr <= iAddr;
        link.portWdata <= oData;
      end
      if (issue && iWr && isRxCtrl)
        rxCtrlShadow <= oData;
      case (state)
        ST_IDLE:
          if (issue && !iWr)
            state <= ST_WAIT;
        ST_WAIT:
          if (link.portRvalid)
          begin
            lastRdata <= link.portRdata;
            state <= ST_IDLE;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule : e1_host_ctrl

/* sim/e1_link_props.sv */
// Checker for the register link: read handshake, strobe spacing, host write values.
// Assumes the link is sampled on clk_sys; signals come from the interface as plain inputs.
`timescale 1ns/1ps
module e1_link_props (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic portWr,
  input wire logic portRd,
  input wire logic [e1_pkg::ADDR_W-1:0] portAddr,
  input wire logic [e1_pkg::DATA_W-1:0] portWdata,
  input wire logic [e1_pkg::DATA_W-1:0] portRdata,
  input wire logic portRvalid
);
  import e1_pkg::*;
  wire logic rxCtrlWr = portWr && portAddr == REG_RX_CTRL;
  wire logic testWr = portWr && (portAddr == REG_TEST_A || portAddr == REG_TEST_B ||
    portAddr == REG_TEST_C);
  wire logic liRise = portWr && portAddr == REG_COMMON_5 && portWdata[LI_RESET_BIT];
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  property p_rd_answer;
    portRd |=> portRvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
  property p_rvalid_cause;
    portRvalid |-> $past(portRd);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("answer without a read");
  property p_rd_wait;
    portRd |=> !portWr && !portRd;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("access issued while read pending");
  property p_one_strobe;
    !(portWr && portRd);
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("read and write together");
  // Read data must hold between answers, the host may sample it late
  property p_rdata_hold;
    !portRvalid |-> $stable(portRdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without answer");
  property p_id_reserved;
    portRvalid && $past(portAddr) == REG_ID |-> portRdata[6:4] == 3'b000;
  endproperty
  a_id_reserved: assert property (p_id_reserved) else $error("identity reserved bits set");
  property p_unused_zero;
    rxCtrlWr |-> !portWdata[RX_UNUSED];
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused control bit written 1");
  property p_dir_store;
    rxCtrlWr && portWdata[RX_DIR] |-> portWdata[RX_ES_EN];
  endproperty
  a_dir_store: assert property (p_dir_store) else $error("sync input without store");
  property p_test_clear;
    testWr |-> portWdata == 8'h00;
  endproperty
  a_test_clear: assert property (p_test_clear) else $error("test register not cleared");
  property p_es_after_li;
    liRise |-> ##[1:40] (portWr && portAddr == REG_COMMON_4 && portWdata == ES_RESET_VAL);
  endproperty
  a_es_after_li: assert property (p_es_after_li) else $error("store reset not written");
endmodule : e1_link_props

/* sim/tb_e1_rx_control_id_regs.sv */
// Bench: host controller and register end joined by the link, driven over AHB-Lite.
// Assumes one 125 MHz clock; framer strobes and straps are driven by the bench.
`timescale 1ns/1ps
module tb_e1_rx_control_id_regs;
  import e1_pkg::*;
  // Short line-interface hold keeps the run small
  localparam int LI_CYC = 20;
  // Arbitrary value
  localparam logic [3:0] REV = 4'h5;
  // Arbitrary value
  localparam logic TYPE_ID = 1'b0;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata, rd;
  logic transceiverSelect0 = 1'b0;
  logic transceiverSelect1 = 1'b0;
  logic frameStrobe = 1'b0;
  logic fasOk = 1'b0;
  logic nfasBit2Err = 1'b0;
  logic casMfStrobe = 1'b0;
  logic crc4MfStrobe = 1'b0;
  logic rxSyncIn = 1'b0;
  logic rxSyncOut, rxSyncOe, esEnable, esSyncIn, liReset, frameAligned, alignLost, resyncPulse;
  logic [1:0] esReset;
  logic [7:0] b;
  int errCount = 0;
  int nCompared = 0;
  int liHigh = 0;
  int es0 = 0;
  int es1 = 0;
  int rsCnt = 0;
  int hits = 0;
  int h0;
  logic [5:0] rAddr[8] = '{REG_TEST_A, REG_TEST_B, REG_TEST_C, REG_RX_CTRL, REG_COMMON_5,
    REG_COMMON_4, REG_ID, 6'h3f};
  logic [7:0] rExp[8] = '{8'h00, 8'h00, 8'h00, 8'h00, LI_RESET_VAL, ES_RESET_VAL,
    {TYPE_ID, 3'b000, REV}, 8'h00};
  logic [7:0] wV[5] = '{8'h10, 8'h20, 8'h30, 8'h08, 8'hd6};
  logic [7:0] rV[5] = '{8'h10, 8'h00, 8'h30, 8'h00, 8'hd6};
  logic [2:0] oV[5] = '{3'b110, 3'b010, 3'b101, 3'b010, 3'b110};
  logic [7:0] tRxCtrl[6] = '{8'h00, 8'h00, 8'h40, 8'h40, 8'hc0, 8'hc0};
  int tSel[6] = '{0, 1, 1, 2, 2, 1};
  int tExp[6] = '{1, 0, 1, 0, 1, 0};
  e1_link_if link();
  e1_host_ctrl u_e1_host_ctrl (.clk_sys, .arst_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .link);
  e1_rx_control_id_regs #(.LI_RECOVER_CYC(LI_CYC), .REVISION(REV), .TYPE_FLAG(TYPE_ID))
    u_e1_rx_control_id_regs (.clk_sys, .arst_n, .link, .transceiverSelect0,
    .transceiverSelect1, .frameStrobe, .fasOk, .nfasBit2Err, .casMfStrobe, .crc4MfStrobe,
    .rxSyncIn, .rxSyncOut, .rxSyncOe, .esEnable, .esSyncIn, .esReset, .liReset,
    .frameAligned, .alignLost, .resyncPulse);
  e1_link_props u_e1_link_props (.clk_sys, .arst_n, .portWr(link.portWr),
    .portRd(link.portRd), .portAddr(link.portAddr), .portWdata(link.portWdata),
    .portRdata(link.portRdata), .portRvalid(link.portRvalid));
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    liHigh += int'(liReset);
    es0 += int'(esReset[0]);
    es1 += int'(esReset[1]);
    rsCnt += int'(resyncPulse);
    hits += int'(rxSyncOut);
  end
  task report_and_stop;
    $display("Compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    n = 0;
    do @(posedge clk_sys); while (hreadyout !== 1'b1 && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1 && ++n < 100);
    q = hrdata;
    check("hresp", 32'(hresp), 32'h0);
    if (n >= 100)
    begin
      errCount++;
      report_and_stop();
    end
  endtask : ahb
  // Commands sent while busy are dropped, so every access waits for idle
  task wait_idle;
    int n;
    n = 0;
    do ahb(1'b0, HOST_STATUS, 32'h0, rd); while (rd[STAT_BUSY] !== 1'b0 && ++n < 50);
    if (n >= 50)
    begin
      errCount++;
      report_and_stop();
    end
  endtask : wait_idle
  task dev_wr(input logic [5:0] a, input logic [7:0] d);
    ahb(1'b1, HOST_CMD, {15'h0, 1'b1, 2'b00, a, d}, rd);
    wait_idle();
  endtask : dev_wr
  task dev_rd(input logic [5:0] a, output logic [7:0] d);
    ahb(1'b1, HOST_CMD, {16'h0, 2'b00, a, 8'h00}, rd);
    wait_idle();
    d = rd[15:8];
  endtask : dev_rd
  task ctrl(input logic [31:0] v);
    ahb(1'b1, HOST_CTRL, v, rd);
    wait_idle();
  endtask : ctrl
  task frames(input logic [7:0] f, input logic [7:0] e, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      frameStrobe <= 1'b1;
      fasOk <= f[i];
      nfasBit2Err <= e[i];
      @(posedge clk_sys);
      frameStrobe <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask : frames
  task pulse(input int s);
    @(posedge clk_sys);
    frameStrobe <= (s == 0);
    casMfStrobe <= (s == 1);
    crc4MfStrobe <= (s == 2);
    @(posedge clk_sys);
    {frameStrobe, casMfStrobe, crc4MfStrobe} <= 3'b000;
    repeat (4) @(posedge clk_sys);
  endtask : pulse
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    errCount++;
    report_and_stop();
  end
  initial
  begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ctrl(32'h1);
    check("initDone", 32'(rd[STAT_INIT_DONE]), 32'h1);
    repeat (LI_CYC + 4) @(posedge clk_sys);
    check("liHigh", 32'(liHigh), 32'(LI_CYC));
    check("esPulses", 32'(es0 + es1 * 16), 32'h11);
    for (int i = 0; i < 8; i++)
    begin
      dev_rd(rAddr[i], b);
      check("readback", 32'(b), 32'(rExp[i]));
    end
    dev_wr(REG_ID, 8'h7a);
    dev_rd(REG_ID, b);
    check("idWrite", 32'(b), 32'(rExp[6]));
    transceiverSelect0 <= 1'b1;
    repeat (4) @(posedge clk_sys);
    dev_rd(REG_ID, b);
    check("idOther", 32'(b), 32'h0);
    transceiverSelect0 <= 1'b0;
    transceiverSelect1 <= 1'b1;
    repeat (4) @(posedge clk_sys);
    dev_rd(REG_ID, b);
    check("idOther", 32'(b), 32'h0);
    transceiverSelect1 <= 1'b0;
    ahb(1'b0, 8'h40, 32'h0, rd);
    check("ahbUnmapped", rd, 32'h0);
    rxSyncIn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      dev_wr(REG_RX_CTRL, wV[i]);
      repeat (3) @(posedge clk_sys);
      dev_rd(REG_RX_CTRL, b);
      check("rxCtrl", 32'(b), 32'(rV[i]));
      check("pins", 32'({esEnable, rxSyncOe, esSyncIn}), 32'(oV[i]));
    end
    for (int i = 0; i < 6; i++)
    begin
      dev_wr(REG_RX_CTRL, tRxCtrl[i]);
      h0 = hits;
      pulse(tSel[i]);
      check("syncHits", 32'(hits - h0), 32'(tExp[i]));
    end
    dev_wr(REG_RX_CTRL, 8'h00);
    frames(8'b101, 8'h0, 3);
    check("lock", 32'({frameAligned, alignLost}), 32'h2);
    frames(8'b101010, 8'b010101, 6);
    check("nfasIgnored", 32'({frameAligned, alignLost}), 32'h2);
    frames(8'h0, 8'h0, 5);
    check("twoErrors", 32'(alignLost), 32'h0);
    frames(8'h0, 8'h0, 1);
    check("loss", 32'({frameAligned, alignLost}), 32'h1);
    frames(8'b101, 8'h0, 3);
    check("autoRelock", 32'({frameAligned, alignLost}), 32'h2);
    dev_wr(REG_RX_CTRL, 8'h04);
    frames(8'b101010, 8'b010101, 6);
    check("nfasLoss", 32'(alignLost), 32'h1);
    dev_wr(REG_RX_CTRL, 8'h06);
    frames(8'b101, 8'h0, 3);
    frames(8'h0, 8'h0, 6);
    frames(8'b101, 8'h0, 3);
    check("noAuto", 32'({frameAligned, alignLost}), 32'h1);
    ctrl(32'h2);
    dev_wr(REG_RX_CTRL, 8'h07);
    ctrl(32'h2);
    repeat (4) @(posedge clk_sys);
    check("resyncCount", 32'(rsCnt), 32'h2);
    frames(8'b101, 8'h0, 3);
    check("manualRelock", 32'({frameAligned, alignLost}), 32'h2);
    report_and_stop();
  end
endmodule : tb_e1_rx_control_id_regs
